// ---- shared/arf_pkg.sv ----
// Shared constants and helpers for the result buffer readout link
package arf_pkg;
	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int WORD_BITS = 32;
	localparam int SAMPLE_BITS = 24;
	localparam int NUM_CH = 4;
	localparam int FRAME_WORDS = 6;
	localparam int FRAME_BITS = 192;
	localparam int BODY_BITS = 160;
	localparam int STAT_FAULT_BIT = 31;
	localparam int STAT_OVF_BIT = 30;
	localparam int STAT_CNT_LSB = 28;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;

	// ----------------------------------------------------------------
	// Buffering and timing counts (core_clk cycles unless noted)
	// ----------------------------------------------------------------
	localparam int BUF_DEPTH = 2;
	localparam int OSR_DEFAULT = 512;
	localparam int DATA_READY_N_LOW_CYC = 4;
	localparam int SCLK_HALF_CYC = 8;
	localparam int MCLK_HALF_CYC = 2;
	localparam int RXFIFO_DEPTH = 16;

	// Bitwise CRC over the status and data words, MSB first
	function automatic logic [15:0] crc16(input logic [BODY_BITS-1:0] d);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = BODY_BITS - 1; i >= 0; i--) begin
			if (c[15] ^ d[i]) begin
				c = {c[14:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		return c;
	endfunction
endpackage

// ---- shared/arf_if.sv ----
// Pin bundle between the converter end and the host controller end
`timescale 1ns/100ps
interface arf_if;
	logic master_clock_in;
	logic sync_pin;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic data_ready_n;

	modport dev (
		input master_clock_in,
		input sync_pin,
		input sclk,
		input cs_n,
		input mosi,
		output miso,
		output data_ready_n
	);

	modport host (
		output master_clock_in,
		output sync_pin,
		output sclk,
		output cs_n,
		output mosi,
		input miso,
		input data_ready_n
	);
endinterface

// ---- core/arf_device.sv ----
// Converter end: two-entry result buffer, data-ready and frame readout
//
// Overview of operation
// [R1] Results held in a two-entry buffer
// [R2] Overflow: data-ready pulses every second period
// [R3] Host reads full frame per data-ready
// [R4] Only a complete frame consumes an entry
// [R5] Partial reads repeat same result twice
// [R6] Host clocks every word slot of frame
// [R7] Async sync edge sets fault flag again
// [R8] Sync is a timing check, not trigger
// [R9] Host supplies the master clock
// [R10] Data-ready asserts on every new result; when full, it asserts only on every second result
// [R11] Host fetches samples over SPI
// [R12] Frame: status, four data, optional CRC
// [R13] Master clock halved; rate divided by ratio
// [R14] Read pops oldest; newer re-announces next period
`timescale 1ns/100ps
module arf_device #(
	parameter int OVERSAMPLING_RATIO = arf_pkg::OSR_DEFAULT,
	parameter bit CRC_EN = 1'b1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Pins toward the host
	arf_if.dev link,
	// Local status
	output logic [1:0] fill_level,
	output logic overflow_seen,
	output logic resync_fault_flag
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef logic [arf_pkg::NUM_CH-1:0][arf_pkg::SAMPLE_BITS-1:0]
		arf_entry_t;

	typedef struct packed {
		logic mclk_s1, mclk_s2, mclk_d;
		logic sync_s1, sync_s2, sync_d;
		logic sclk_s1, sclk_s2, sclk_d;
		logic cs_s1, cs_s2, cs_d;
		logic mosi_s1, mosi_s2;
		logic mod_div;
		logic [15:0] osr_cnt;
		logic [21:0] sample_cnt;
		logic [arf_pkg::BUF_DEPTH-1:0] [$bits(arf_entry_t)-1:0] buf_mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
		logic ovf_alt;
		logic ovf_flag;
		logic fault;
		logic data_ready_n_n;
		logic [3:0] data_ready_n_cnt;
		logic in_frame;
		logic [7:0] bitcnt;
		logic clr_req;
		logic [arf_pkg::FRAME_BITS-1:0] shreg;
		logic miso;
	} arf_dev_state_t;

	arf_dev_state_t s_r, s_nxt;

	// Sign extension of a sample into a frame word
	function automatic logic [arf_pkg::WORD_BITS-1:0] sx(
		input logic [arf_pkg::SAMPLE_BITS-1:0] v);
		return {{(arf_pkg::WORD_BITS - arf_pkg::SAMPLE_BITS){v[23]}}, v};
	endfunction

	// ----------------------------------------------------------------
	// Frame image built from the oldest entry
	// ----------------------------------------------------------------
	arf_entry_t head;
	logic [arf_pkg::WORD_BITS-1:0] status_word;
	logic [arf_pkg::BODY_BITS-1:0] body;
	logic [arf_pkg::WORD_BITS-1:0] crc_word;

	// Stale head is sent when empty; host sees count zero in status
	always_comb begin
		head = arf_entry_t'(s_r.buf_mem[s_r.rd_ptr]);
		status_word = '0;
		status_word[arf_pkg::STAT_FAULT_BIT] = s_r.fault;
		status_word[arf_pkg::STAT_OVF_BIT] = s_r.ovf_flag;
		status_word[arf_pkg::STAT_CNT_LSB +: 2] = s_r.count;
		body = {status_word, sx(head[0]), sx(head[1]), sx(head[2]),
			sx(head[3])}; // [R12]
		crc_word = CRC_EN ? {arf_pkg::crc16(body), 16'h0000} : '0; // [R12]
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic mclk_rise, sync_edge, sclk_rise, sclk_fall, cs_fall, cs_rise;
	logic conv, full_read;
	arf_entry_t new_entry;

	always_comb begin
		s_nxt = s_r;
		conv = 1'b0;
		full_read = 1'b0;
		new_entry = '0;
		// Two-stage synchronisers on every pin input
		s_nxt.mclk_s1 = link.master_clock_in; // [R9]
		s_nxt.mclk_s2 = s_r.mclk_s1;
		s_nxt.mclk_d = s_r.mclk_s2;
		s_nxt.sync_s1 = link.sync_pin;
		s_nxt.sync_s2 = s_r.sync_s1;
		s_nxt.sync_d = s_r.sync_s2;
		s_nxt.sclk_s1 = link.sclk;
		s_nxt.sclk_s2 = s_r.sclk_s1;
		s_nxt.sclk_d = s_r.sclk_s2;
		s_nxt.cs_s1 = link.cs_n;
		s_nxt.cs_s2 = s_r.cs_s1;
		s_nxt.cs_d = s_r.cs_s2;
		s_nxt.mosi_s1 = link.mosi;
		s_nxt.mosi_s2 = s_r.mosi_s1;
		mclk_rise = s_r.mclk_s2 & ~s_r.mclk_d;
		sync_edge = s_r.sync_s2 ^ s_r.sync_d;
		sclk_rise = s_r.sclk_s2 & ~s_r.sclk_d;
		sclk_fall = ~s_r.sclk_s2 & s_r.sclk_d;
		cs_fall = ~s_r.cs_s2 & s_r.cs_d;
		cs_rise = s_r.cs_s2 & ~s_r.cs_d;

		// Modulator tick on every second master rise, result per ratio
		if (mclk_rise) begin
			s_nxt.mod_div = ~s_r.mod_div; // [R13]
			if (s_r.mod_div) begin
				if (s_r.osr_cnt == 16'(OVERSAMPLING_RATIO - 1)) begin
					s_nxt.osr_cnt = '0;
					conv = 1'b1; // [R13]
				end else begin
					s_nxt.osr_cnt = s_r.osr_cnt + 16'h0001;
				end
			end
		end

		// Data-ready low pulse length
		if (s_r.data_ready_n_cnt != 4'h0) begin
			s_nxt.data_ready_n_cnt = s_r.data_ready_n_cnt - 4'h1;
			if (s_r.data_ready_n_cnt == 4'h1) begin
				s_nxt.data_ready_n_n = 1'b1;
			end
		end

		// Frame readout: shift on rising sclk, count on falling
		if (cs_fall) begin
			s_nxt.in_frame = 1'b1;
			s_nxt.bitcnt = '0;
			s_nxt.clr_req = 1'b0;
			s_nxt.shreg = {body, crc_word}; // [R12]
		end else if (s_r.in_frame) begin
			if (sclk_rise) begin
				s_nxt.miso = s_r.shreg[arf_pkg::FRAME_BITS-1];
				s_nxt.shreg = {s_r.shreg[arf_pkg::FRAME_BITS-2:0], 1'b0};
			end
			if (sclk_fall && s_r.bitcnt != 8'(arf_pkg::FRAME_BITS)) begin
				s_nxt.bitcnt = s_r.bitcnt + 8'h01;
				if (s_r.bitcnt == 8'h00) begin
					s_nxt.clr_req = s_r.mosi_s2;
				end
			end
			if (cs_rise) begin
				s_nxt.in_frame = 1'b0;
				// Short frames leave the entry in place
				full_read = (s_r.bitcnt == 8'(arf_pkg::FRAME_BITS)); // [R4] [R6]
			end
		end

		// Complete read consumes the oldest entry and the overflow flag, and the fault flag when the clear bit was set
		if (full_read) begin
			if (s_nxt.count != 2'd0) begin
				s_nxt.rd_ptr = ~s_r.rd_ptr; // [R14]
				s_nxt.count = s_nxt.count - 2'd1; // [R4]
			end
			s_nxt.ovf_flag = 1'b0;
			if (s_r.clr_req) begin
				s_nxt.fault = 1'b0;
			end
		end

		// New result; a pending newer entry is re-announced here too
		if (conv) begin
			s_nxt.sample_cnt = s_r.sample_cnt + 22'h000001;
			for (int c = 0; c < arf_pkg::NUM_CH; c++) begin
				new_entry[c] = {s_r.sample_cnt, 2'(c)};
			end
			if (s_nxt.count < 2'(arf_pkg::BUF_DEPTH)) begin
				s_nxt.buf_mem[s_r.wr_ptr] = new_entry; // [R1]
				s_nxt.wr_ptr = ~s_r.wr_ptr;
				s_nxt.count = s_nxt.count + 2'd1;
				s_nxt.ovf_alt = 1'b0;
				s_nxt.data_ready_n_n = 1'b0; // [R10] [R14]
				s_nxt.data_ready_n_cnt = 4'(arf_pkg::DATA_READY_N_LOW_CYC);
			end else begin
				// Full: alternate drop and replace, so the head changes
				// and data-ready fires only every second period
				s_nxt.ovf_flag = 1'b1; // [R1]
				s_nxt.ovf_alt = ~s_r.ovf_alt; // [R2] [R5]
				if (s_r.ovf_alt) begin
					s_nxt.buf_mem[s_r.wr_ptr] = new_entry;
					s_nxt.wr_ptr = ~s_r.wr_ptr;
					s_nxt.rd_ptr = ~s_nxt.rd_ptr;
					s_nxt.data_ready_n_n = 1'b0; // [R2]
					s_nxt.data_ready_n_cnt = 4'(arf_pkg::DATA_READY_N_LOW_CYC);
				end
			end
		end

		// Sync edge off the master rise is asynchronous; set beats clear
		if (sync_edge && !mclk_rise) begin
			s_nxt.fault = 1'b1; // [R7] [R8]
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.data_ready_n_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from state flops
	assign link.miso = s_r.miso;
	assign link.data_ready_n = s_r.data_ready_n_n;
	assign fill_level = s_r.count;
	assign overflow_seen = s_r.ovf_flag;
	assign resync_fault_flag = s_r.fault;
endmodule

// ---- core/arf_host.sv ----
// Host end: master clock, sync drive, frame reader and receive FIFO
`timescale 1ns/100ps
module arf_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
		logic ov;
		logic [WIDTH-1:0] od;
	} arf_fifo_state_t;

	arf_fifo_state_t s_r, s_nxt;
	logic push, load;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	// Output stage register keeps the drain side flop-driven
	always_comb begin
		s_nxt = s_r;
		push = in_valid && (s_r.cnt != CW'(DEPTH));
		load = (!s_r.ov || out_ready) && (s_r.cnt != '0);
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = ptr_inc(s_r.wp);
		end
		if (load) begin
			s_nxt.od = s_r.mem[s_r.rp];
			s_nxt.ov = 1'b1;
			s_nxt.rp = ptr_inc(s_r.rp);
		end else if (out_ready) begin
			s_nxt.ov = 1'b0;
		end
		if (push && !load) begin
			s_nxt.cnt = s_r.cnt + CW'(1);
		end else if (load && !push) begin
			s_nxt.cnt = s_r.cnt - CW'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign in_ready = (s_r.cnt != CW'(DEPTH));
	assign out_valid = s_r.ov;
	assign out_data = s_r.od;
endmodule

module arf_host #(
	parameter int SCLK_HALF = arf_pkg::SCLK_HALF_CYC,
	parameter int MCLK_HALF = arf_pkg::MCLK_HALF_CYC,
	parameter int DEPTH = arf_pkg::RXFIFO_DEPTH
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Pins toward the converter
	arf_if.host link,
	// Control
	input wire logic stream_en,
	input wire logic clear_fault,
	input wire logic sync_level,
	input wire logic [2:0] frame_words,
	// Received words
	output logic word_valid,
	output logic [arf_pkg::WORD_BITS-1:0] word_data,
	input wire logic word_ready,
	output logic frame_busy
);
	typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_DONE} arf_hst_t;

	typedef struct packed {
		arf_hst_t st;
		logic [7:0] mdiv;
		logic mclk;
		logic sync;
		logic data_ready_n_s1, data_ready_n_s2, data_ready_n_d;
		logic miso_s1, miso_s2;
		logic sclk;
		logic cs_n;
		logic mosi;
		logic [7:0] hc;
		logic [7:0] bitcnt;
		logic [7:0] nbits;
		logic [arf_pkg::WORD_BITS-1:0] word_sh;
		logic push_v;
		logic [arf_pkg::WORD_BITS-1:0] push_d;
	} arf_hst_state_t;

	arf_hst_state_t s_r, s_nxt;
	logic fifo_in_ready;
	logic data_ready_n_fall, half_done;
	logic [arf_pkg::WORD_BITS-1:0] word_new;

	// Receive buffer; a full buffer holds sclk and so stalls the frame
	arf_fifo #(.WIDTH(arf_pkg::WORD_BITS), .DEPTH(DEPTH)) u_rx (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.in_valid(s_r.push_v),
		.in_data(s_r.push_d),
		.in_ready(fifo_in_ready),
		.out_valid(word_valid),
		.out_data(word_data),
		.out_ready(word_ready)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.data_ready_n_s1 = link.data_ready_n;
		s_nxt.data_ready_n_s2 = s_r.data_ready_n_s1;
		s_nxt.data_ready_n_d = s_r.data_ready_n_s2;
		s_nxt.miso_s1 = link.miso;
		s_nxt.miso_s2 = s_r.miso_s1;
		data_ready_n_fall = s_r.data_ready_n_d & ~s_r.data_ready_n_s2;
		half_done = (s_r.hc == 8'(SCLK_HALF - 1));
		word_new = {s_r.word_sh[arf_pkg::WORD_BITS-2:0], s_r.miso_s2};

		// Master clock from a divider; sync moves only on its rise
		if (s_r.mdiv == 8'(MCLK_HALF - 1)) begin
			s_nxt.mdiv = '0;
			s_nxt.mclk = ~s_r.mclk; // [R9]
			if (!s_r.mclk) begin
				s_nxt.sync = sync_level; // [R8]
			end
		end else begin
			s_nxt.mdiv = s_r.mdiv + 8'h01;
		end

		if (s_r.push_v && fifo_in_ready) begin
			s_nxt.push_v = 1'b0;
		end

		s_nxt.hc = half_done ? 8'h00 : s_r.hc + 8'h01;
		unique case (s_r.st)
			H_IDLE: begin
				s_nxt.hc = '0;
				// One frame per data-ready falling edge
				if (data_ready_n_fall && stream_en) begin
					s_nxt.cs_n = 1'b0; // [R3] [R11]
					s_nxt.mosi = clear_fault;
					s_nxt.bitcnt = '0;
					s_nxt.nbits = {frame_words, 5'b00000}; // [R6]
					s_nxt.st = H_LOW;
				end
			end
			H_LOW: begin
				if (half_done) begin
					if (s_r.bitcnt == s_r.nbits) begin
						s_nxt.st = H_DONE;
					end else if (s_r.push_v) begin
						s_nxt.hc = s_r.hc;
					end else begin
						s_nxt.sclk = 1'b1;
						s_nxt.st = H_HIGH;
					end
				end
			end
			H_HIGH: begin
				if (half_done) begin
					s_nxt.sclk = 1'b0;
					s_nxt.word_sh = word_new;
					s_nxt.bitcnt = s_r.bitcnt + 8'h01;
					if (s_r.bitcnt[4:0] == 5'h1F) begin
						s_nxt.push_v = 1'b1;
						s_nxt.push_d = word_new;
					end
					s_nxt.st = H_LOW;
				end
			end
			H_DONE: begin
				if (half_done) begin
					s_nxt.cs_n = 1'b1;
					s_nxt.mosi = 1'b0;
					s_nxt.st = H_IDLE;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.st <= H_IDLE;
			s_r.cs_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.master_clock_in = s_r.mclk;
	assign link.sync_pin = s_r.sync;
	assign link.sclk = s_r.sclk;
	assign link.cs_n = s_r.cs_n;
	assign link.mosi = s_r.mosi;
	assign frame_busy = ~s_r.cs_n;
endmodule

// ---- dv/arf_link_asserts.sv ----
// Pin-level checks on the link between converter end and host end
`timescale 1ns/100ps
module arf_link_asserts (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Link pins
	input wire logic master_clock_in,
	input wire logic sync_pin,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic miso,
	input wire logic data_ready_n
);
	// One conversion period: two master rises per tick, ratio ticks
	localparam int PER = 4 * arf_pkg::OSR_DEFAULT *
		arf_pkg::MCLK_HALF_CYC;
	logic [13:0] gap_r;
	logic seen_r;
	logic [7:0] bits_r;
	logic [4:0] rise_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// -----------------------------------------------------------
	// Helper counters
	// -----------------------------------------------------------
	// Gap since data-ready fall saturates, so a stall never wraps
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			gap_r <= '0;
			seen_r <= 1'b0;
			bits_r <= '0;
			rise_r <= '0;
		end else begin
			gap_r <= $fell(data_ready_n) ? '0 : gap_r + 14'(gap_r != '1);
			seen_r <= seen_r | $fell(data_ready_n);
			bits_r <= $fell(cs_n) ? '0 : bits_r + 8'($rose(sclk));
			rise_r <= {rise_r[3:0], $rose(sclk)};
		end
	end

	// -----------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------
	chk_ready_width: assert property (
		$fell(data_ready_n) |=> !data_ready_n [*3] ##1 data_ready_n)
		else $error("data-ready pulse width wrong");
	chk_ready_period: assert property (
		$fell(data_ready_n) |-> !seen_r || gap_r == 14'(PER - 1)
		|| gap_r == 14'(2 * PER - 1))
		else $error("data-ready spacing off the conversion period");
	chk_cs_after_ready: assert property (
		$fell(cs_n) |-> seen_r && gap_r >= 14'h0002 && gap_r <= 14'h000A)
		else $error("frame start not tied to a data-ready fall");
	chk_frame_bits: assert property (
		$rose(cs_n) |-> bits_r[4:0] == 5'h00 && bits_r <= 8'hC0)
		else $error("frame not made of whole words");
	chk_sclk_idle: assert property (
		cs_n |-> !sclk)
		else $error("serial clock active outside a frame");
	chk_miso_timing: assert property (
		$changed(miso) |-> |rise_r[3:1])
		else $error("data out moved away from a clock rise");
	chk_sync_on_mclk: assert property (
		$changed(sync_pin) |-> $rose(master_clock_in))
		else $error("sync level moved off a master rise");
	chk_mclk_period: assert property (
		$changed(master_clock_in) |=> $stable(master_clock_in)
		##1 $changed(master_clock_in))
		else $error("master clock half period wrong");
endmodule

// ---- dv/adc_result_fifo_readout_tb_top.sv ----
// Bench: host end streams result frames from the converter end
`timescale 1ns/100ps
module adc_result_fifo_readout_tb_top;
	// One conversion period: two master rises per tick, ratio ticks
	localparam int PER = 4 * arf_pkg::OSR_DEFAULT *
		arf_pkg::MCLK_HALF_CYC;
	logic core_clk, sys_rst, stream_en, clear_fault, sync_level;
	logic word_valid, word_ready, frame_busy, overflow_seen;
	logic resync_fault_flag, f_flag;
	logic [1:0] fill_level;
	logic [1:0] mc_cnt = 2'h0;
	logic [2:0] frame_words;
	logic [15:0] crc;
	logic [31:0] word_data, p;
	logic [31:0] fr [6];
	logic [3:0] st [4] = '{4'h1, 4'h2, 4'h6, 4'h6};
	int hd [4] = '{3, 3, 4, 6};
	int bad_count, tests_run, cyc, n;

	arf_if if1();
	arf_if if2();

	// -----------------------------------------------------------
	// Clock, instances, watchdog
	// -----------------------------------------------------------
	// 10 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	arf_device #(.OVERSAMPLING_RATIO(512), .CRC_EN(1'b1)) arf_device_i (
		.core_clk(core_clk), .sys_rst(sys_rst), .link(if1),
		.fill_level(fill_level), .overflow_seen(overflow_seen),
		.resync_fault_flag(resync_fault_flag));
	arf_device #(.OVERSAMPLING_RATIO(512), .CRC_EN(1'b1)) arf_device_f_i (
		.core_clk(core_clk), .sys_rst(sys_rst), .link(if2),
		.fill_level(), .overflow_seen(), .resync_fault_flag(f_flag));
	arf_host arf_host_i (
		.core_clk(core_clk), .sys_rst(sys_rst), .link(if1),
		.stream_en(stream_en), .clear_fault(clear_fault),
		.sync_level(sync_level), .frame_words(frame_words),
		.word_valid(word_valid), .word_data(word_data),
		.word_ready(word_ready), .frame_busy(frame_busy));
	arf_link_asserts arf_link_asserts_i (
		.core_clk(core_clk), .sys_rst(sys_rst),
		.master_clock_in(if1.master_clock_in), .sync_pin(if1.sync_pin),
		.sclk(if1.sclk), .cs_n(if1.cs_n), .miso(if1.miso),
		.data_ready_n(if1.data_ready_n));

	// Free master clock for the spare converter, period four cycles
	always @(posedge core_clk) begin
		#10;
		mc_cnt <= mc_cnt + 2'h1;
		if2.master_clock_in <= mc_cnt[1];
	end

	// Watchdog: whole run needs about 70k cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 90000) begin
			check(32'h0, 32'h1);
			conclude();
		end
	end

	// -----------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------
	function automatic logic [31:0] sample(input int k, input int c);
		logic [23:0] s;
		s = {k[21:0], c[1:0]};
		return {{8{s[23]}}, s};
	endfunction

	// Own CRC so the frame check does not lean on design code
	function automatic logic [15:0] ref_crc(input logic [159:0] d);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 159; i >= 0; i--) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
		end
		return c;
	endfunction

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#10;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One word from the receive queue; ready drops a cycle between words
	task automatic read_word(output logic [31:0] w);
		int k;
		k = 0;
		while (word_valid !== 1'b1 && k < 12000) begin
			tick(1);
			k++;
		end
		w = word_data;
		word_ready = 1'b1;
		tick(1);
		word_ready = 1'b0;
		tick(1);
	endtask

	task automatic read_frame(input int nw);
		for (int i = 0; i < nw; i++) read_word(fr[i]);
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		while (frame_busy !== 1'b0 && k < 4000) begin
			tick(1);
			k++;
		end
		tick(6);
	endtask

	// Wait for the next frame to start and run to its end
	task automatic wait_frame();
		int k;
		k = 0;
		while (frame_busy !== 1'b1 && k < 6000) begin
			tick(1);
			k++;
		end
		wait_idle();
	endtask

	// -----------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		{stream_en, clear_fault, sync_level, word_ready} = 4'h0;
		frame_words = 3'h0;
		{if2.cs_n, if2.sclk, if2.mosi, if2.sync_pin} = 4'h8;
		tick(5);
		sys_rst = 1'b0;
		{stream_en, clear_fault, sync_level, frame_words} = 6'h3E;
		// Sync edge on the spare converter away from any master rise
		while (if2.master_clock_in !== 1'b1) tick(1);
		if2.sync_pin = 1'b1;
		tick(10);
		check(32'(f_flag), 32'h1);
		check(32'(resync_fault_flag), 32'h0);
		// Whole spare frame with the clear bit set, then a second stray
		// sync edge must raise the flag again
		{if2.cs_n, if2.mosi} = 2'b01;
		tick(4);
		repeat (arf_pkg::FRAME_BITS) begin
			if2.sclk = 1'b1;
			tick(4);
			if2.sclk = 1'b0;
			tick(4);
		end
		tick(4);
		{if2.cs_n, if2.mosi} = 2'b10;
		tick(6);
		check(32'(f_flag), 32'h0);
		while (if2.master_clock_in !== 1'b1) tick(1);
		if2.sync_pin = 1'b0;
		tick(10);
		check(32'(f_flag), 32'h1);
		$display("test resync flag done");
		// Three whole frames left in the receive queue: 17 words fit,
		// the last one waits in the host without holding up its frame
		for (int k = 0; k < 3; k++) begin
			wait_frame();
			check(32'(fill_level), 32'h0);
		end
		check(32'(frame_busy), 32'h0);
		check(32'(word_valid), 32'h1);
		// Drain in frame order: status, four samples, CRC
		for (int k = 0; k < 3; k++) begin
			read_frame(6);
			check(fr[0], 32'h1000_0000);
			for (int c = 0; c < 4; c++) begin
				check(fr[c + 1], sample(k, c));
			end
			crc = ref_crc({32'h1000_0000, sample(k, 0), sample(k, 1),
				sample(k, 2), sample(k, 3)});
			check(fr[5], {crc, 16'h0000});
		end
		check(32'(word_valid), 32'h0);
		$display("test full frames done");
		// Partial frames leave the head in place; same result twice
		frame_words = 3'h3;
		for (int k = 0; k < 4; k++) begin
			read_frame(3);
			check(fr[0], {st[k], 28'h0});
			check(fr[1], sample(hd[k], 0));
		end
		wait_idle();
		check(32'(fill_level), 32'h2);
		check(32'(overflow_seen), 32'h1);
		$display("test partial frames done");
		// Unread and full: one data-ready fall per two periods
		stream_en = 1'b0;
		n = 0;
		for (int i = 0; i < 4 * PER; i++) begin
			p[0] = if1.data_ready_n;
			tick(1);
			if (p[0] === 1'b1 && if1.data_ready_n === 1'b0) n++;
		end
		check(32'(n), 32'h2);
		$display("test overflow rate done");
		// Resume: overflow reported once, cleared by a whole frame
		{stream_en, frame_words} = 4'hE;
		read_frame(6);
		check(fr[0], 32'h6000_0000);
		wait_idle();
		check(32'(overflow_seen), 32'h0);
		read_frame(6);
		check(fr[0], 32'h2000_0000);
		$display("test recovery done");
		conclude();
	end
endmodule
